/* File: hdl/light_sensor_control_regs.sv */
// Register map, measurement sequencer and light interrupt logic.
// Assumes an ADC front end on clk_sys and an external pull-up on the
// interrupt pin; register accesses arrive on the link clock.
module light_sensor_control_regs #(
	parameter int STEP_CYCLES = sensor_pkg::STEP_CYCLES,
	parameter logic [7:0] REV_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0] PART_CODE = 8'h3c // Arbitrary value
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic link_access,
	input wire sensor_pkg::reg_req_s link_req,
	output logic link_busy,
	output logic [7:0] link_rdata,
	input wire logic adc_valid,
	input wire sensor_pkg::adc_result_s adc_res,
	input wire logic calib_done,
	output sensor_pkg::analog_ctrl_s analog,
	output logic irq_pin_out,
	output logic irq_pin_oe
);
	localparam int PW = $clog2(STEP_CYCLES);

	typedef struct packed {
		logic [7:0] fc;
		logic [7:0] it_steps;
		logic [7:0] pause_steps;
		logic [15:0] low_thr;
		logic [15:0] high_thr;
		logic [7:0] thr_latch;
		logic [7:0] irq_persistence;
		logic [7:0] config_second;
		logic [7:0] config_third;
		logic [7:0] config_fourth;
		logic [7:0] cfg4;
		logic [7:0] az_cfg;
		logic [7:0] irq_mask;
		logic [7:0] status;
		logic [15:0] ch0;
		logic [15:0] ch1;
		logic [15:0] ch2;
		logic [15:0] ch3;
		sensor_pkg::seq_state_e seq;
		logic [PW-1:0] presc;
		logic [7:0] cnt;
		logic [3:0] sub;
		logic [5:0] irq_persistence_cnt;
		logic az_pending;
		sensor_pkg::analog_ctrl_s ana;
		logic int_drive;
	} ctrl_state_s;

	ctrl_state_s st, next_st;
	logic sys_pulse;
	sensor_pkg::reg_req_s sys_req;
	logic [7:0] rd_data;
	logic wr;
	logic meas_on;
	logic tick;
	logic [15:0] max_cnt;
	logic [5:0] need;
	logic out_of_range;
	logic light_set;
	logic [5:0] irq_persistence_next;

	// Consecutive out-of-range results needed before the flag sets
	function automatic logic [5:0] irq_persistence_need(input logic [3:0] v);
		logic [6:0] m;
		m = ({3'h0, v} * sensor_pkg::IRQ_PERSISTENCE_MULT) - sensor_pkg::IRQ_PERSISTENCE_OFFSET;
		if (v <= sensor_pkg::IRQ_PERSISTENCE_LINEAR_MAX) begin
			irq_persistence_need = {2'h0, v};
		end else begin
			irq_persistence_need = m[5:0];
		end
	endfunction : irq_persistence_need

	// Largest count an integration of s+1 steps can reach
	function automatic logic [15:0] full_count(input logic [7:0] s);
		if (s >= sensor_pkg::FULL_STEPS) begin
			full_count = sensor_pkg::MAX_FULL;
		end else begin
			full_count = {s[5:0], 10'h3ff};
		end
	endfunction : full_count

	// Register accesses cross from the link clock by toggle handshake
	reg_port_cdc u_port (
		.link_clk(link_clk),
		.clk_sys(clk_sys),
		.rst(rst),
		.link_access(link_access),
		.link_req(link_req),
		.link_busy(link_busy),
		.link_rdata(link_rdata),
		.sys_pulse(sys_pulse),
		.sys_req(sys_req),
		.sys_rdata(rd_data)
	);

	// Step tick only counts while the oscillator bit is set
	assign wr = sys_pulse && sys_req.write;
	assign meas_on = st.fc[sensor_pkg::FC_OSC_ON] &&
		st.fc[sensor_pkg::FC_MEAS_EN];
	assign tick = st.fc[sensor_pkg::FC_OSC_ON] &&
		(st.presc == PW'(STEP_CYCLES - 1));
	assign max_cnt = full_count(st.it_steps);
	assign need = irq_persistence_need(st.irq_persistence[3:0]);
	// Only channel 0 is compared; other channels never raise the flag
	assign out_of_range = (adc_res.ch0 < st.low_thr) ||
		(adc_res.ch0 > st.high_thr);
	assign irq_persistence_next = (st.irq_persistence_cnt == 6'h3f) ? st.irq_persistence_cnt :
		st.irq_persistence_cnt + 6'h01;
	assign light_set = meas_on && adc_valid &&
		((need == 6'h00) || (out_of_range && irq_persistence_next >= need));

	// Read mux; unmapped offsets read as zero
	always_comb begin
		case (sys_req.addr)
			sensor_pkg::A_FUNC_CTRL: rd_data = st.fc;
			sensor_pkg::A_INT_STEPS: rd_data = st.it_steps;
			sensor_pkg::A_PAUSE_STEPS: rd_data = st.pause_steps;
			sensor_pkg::A_LOW_LO: rd_data = st.low_thr[7:0];
			sensor_pkg::A_LOW_HI: rd_data = st.low_thr[15:8];
			sensor_pkg::A_HIGH_LO: rd_data = st.high_thr[7:0];
			sensor_pkg::A_HIGH_HI: rd_data = st.high_thr[15:8];
			sensor_pkg::A_IRQ_PERSISTENCE: rd_data = st.irq_persistence;
			sensor_pkg::A_CFG_FIRST: rd_data = st.config_second;
			sensor_pkg::A_CFG_SECOND: rd_data = st.config_third;
			sensor_pkg::A_REV: rd_data = REV_CODE;
			sensor_pkg::A_PART: rd_data = PART_CODE;
			sensor_pkg::A_FLAGS: rd_data = st.status;
			sensor_pkg::A_Z_LO: rd_data = st.ch0[7:0];
			sensor_pkg::A_Z_HI: rd_data = st.ch0[15:8];
			sensor_pkg::A_Y_LO: rd_data = st.ch1[7:0];
			sensor_pkg::A_Y_HI: rd_data = st.ch1[15:8];
			sensor_pkg::A_IR1_LO: rd_data = st.ch2[7:0];
			sensor_pkg::A_IR1_HI: rd_data = st.ch2[15:8];
			sensor_pkg::A_CH3_LO: rd_data = st.ch3[7:0];
			sensor_pkg::A_CH3_HI: rd_data = st.ch3[15:8];
			sensor_pkg::A_CFG_THIRD: rd_data = st.config_fourth;
			sensor_pkg::A_CFG_FOURTH: rd_data = st.cfg4;
			sensor_pkg::A_AZ_CFG: rd_data = st.az_cfg;
			sensor_pkg::A_IRQ_MASK: rd_data = st.irq_mask;
			default: rd_data = 8'h00;
		endcase
	end

	// Next state: register writes, sequencer, results, flags
	always_comb begin
		next_st = st;
		next_st.ana.autozero_start = 1'b0;
		next_st.ana.integ_done = 1'b0;
		// Prescaler stands at zero while the oscillator is off
		if (!st.fc[sensor_pkg::FC_OSC_ON] || tick) begin
			next_st.presc = '0;
		end else begin
			next_st.presc = st.presc + PW'(1);
		end
		if (wr) begin
			case (sys_req.addr)
				sensor_pkg::A_FUNC_CTRL: begin
					next_st.fc = sys_req.wdata;
					// Auto-zero whenever a write sets both bits while they were not both set before
					if (sys_req.wdata[1:0] == 2'b11 && st.fc[1:0] != 2'b11) begin
						next_st.az_pending = 1'b1;
					end
				end
				sensor_pkg::A_INT_STEPS: next_st.it_steps = sys_req.wdata;
				sensor_pkg::A_PAUSE_STEPS: next_st.pause_steps = sys_req.wdata;
				sensor_pkg::A_LOW_LO: next_st.thr_latch = sys_req.wdata;
				sensor_pkg::A_HIGH_LO: next_st.thr_latch = sys_req.wdata;
				// High byte applies the pair at once, avoiding a torn limit
				sensor_pkg::A_LOW_HI:
					next_st.low_thr = {sys_req.wdata, st.thr_latch};
				sensor_pkg::A_HIGH_HI:
					next_st.high_thr = {sys_req.wdata, st.thr_latch};
				sensor_pkg::A_IRQ_PERSISTENCE: next_st.irq_persistence = sys_req.wdata;
				sensor_pkg::A_CFG_FIRST: next_st.config_second = sys_req.wdata;
				sensor_pkg::A_CFG_SECOND: next_st.config_third = sys_req.wdata;
				sensor_pkg::A_FLAGS:
					next_st.status = st.status &
						~(sys_req.wdata & sensor_pkg::FLAG_W1C);
				sensor_pkg::A_CFG_THIRD: next_st.config_fourth = sys_req.wdata;
				sensor_pkg::A_CFG_FOURTH: next_st.cfg4 = sys_req.wdata;
				sensor_pkg::A_AZ_CFG: next_st.az_cfg = sys_req.wdata;
				sensor_pkg::A_IRQ_MASK: next_st.irq_mask = sys_req.wdata;
				default: next_st.fc = st.fc;
			endcase
		end
		// Measurement sequencer; any loss of power or enable idles it
		case (st.seq)
			sensor_pkg::SEQ_IDLE: begin
				if (meas_on && st.az_pending) begin
					next_st.seq = sensor_pkg::SEQ_AZERO;
					next_st.az_pending = 1'b0;
					next_st.ana.autozero_start = 1'b1;
				end else if (meas_on) begin
					// Restart the prescaler so the first step is a whole one
					next_st.presc = '0;
					next_st.seq = sensor_pkg::SEQ_INTEG;
					next_st.cnt = st.it_steps;
				end
			end
			sensor_pkg::SEQ_AZERO: begin
				if (!meas_on) begin
					next_st.seq = sensor_pkg::SEQ_IDLE;
				end else if (calib_done) begin
					next_st.presc = '0;
					next_st.seq = sensor_pkg::SEQ_INTEG;
					next_st.cnt = st.it_steps;
				end
			end
			sensor_pkg::SEQ_INTEG: begin
				if (!meas_on) begin
					next_st.seq = sensor_pkg::SEQ_IDLE;
				end else if (tick && st.cnt == 8'h00) begin
					next_st.ana.integ_done = 1'b1;
					if (st.fc[sensor_pkg::FC_PAUSE_EN]) begin
						next_st.seq = sensor_pkg::SEQ_PAUSE;
						next_st.cnt = st.pause_steps;
						next_st.sub = 4'h0;
					end else begin
						next_st.cnt = st.it_steps;
					end
				end else if (tick) begin
					next_st.cnt = st.cnt - 8'h01;
				end
			end
			sensor_pkg::SEQ_PAUSE: begin
				if (!meas_on) begin
					next_st.sub = 4'h0;
					next_st.seq = sensor_pkg::SEQ_IDLE;
				end else if (!st.fc[sensor_pkg::FC_PAUSE_EN]) begin
					// Timer switched off mid-wait: start integrating now
					next_st.seq = sensor_pkg::SEQ_INTEG;
					next_st.cnt = st.it_steps;
					next_st.sub = 4'h0;
					next_st.presc = '0;
				end else if (tick && st.config_second[sensor_pkg::CF1_LONG_PAUSE] &&
					st.sub != sensor_pkg::LONG_FACTOR - 4'h1) begin
					next_st.sub = st.sub + 4'h1;
				end else if (tick && st.cnt == 8'h00) begin
					next_st.sub = 4'h0;
					next_st.seq = sensor_pkg::SEQ_INTEG;
					next_st.cnt = st.it_steps;
				end else if (tick) begin
					next_st.sub = 4'h0;
					next_st.cnt = st.cnt - 8'h01;
				end
			end
			default: next_st.seq = sensor_pkg::SEQ_IDLE;
		endcase
		// Results: clamp to the step-limited maximum, keep channel 3 source
		if (adc_valid) begin
			next_st.ch0 = (adc_res.ch0 > max_cnt) ? max_cnt : adc_res.ch0;
			next_st.ch1 = (adc_res.ch1 > max_cnt) ? max_cnt : adc_res.ch1;
			next_st.ch2 = (adc_res.ch2 > max_cnt) ? max_cnt : adc_res.ch2;
			if (st.config_third[sensor_pkg::CF2_CH3_SEL]) begin
				next_st.ch3 = (adc_res.ch3_ir > max_cnt) ?
					max_cnt : adc_res.ch3_ir;
			end else begin
				next_st.ch3 = (adc_res.ch3_x > max_cnt) ?
					max_cnt : adc_res.ch3_x;
			end
		end
		// Persistence counter; an in-range result breaks the run
		if (!meas_on) begin
			next_st.irq_persistence_cnt = 6'h00;
		end else if (adc_valid && !out_of_range) begin
			next_st.irq_persistence_cnt = 6'h00;
		end else if (adc_valid) begin
			next_st.irq_persistence_cnt = irq_persistence_next;
		end
		// Hardware sets come after the write so a set beats a clear
		if (adc_valid && adc_res.saturated) begin
			next_st.status[sensor_pkg::ST_SAT] = 1'b1;
		end
		if (light_set) begin
			next_st.status[sensor_pkg::ST_LIGHT] = 1'b1;
		end
		if (st.seq == sensor_pkg::SEQ_AZERO && calib_done) begin
			next_st.status[sensor_pkg::ST_CAL] = 1'b1;
		end
		next_st.int_drive = next_st.status[sensor_pkg::ST_LIGHT] &&
			next_st.irq_mask[sensor_pkg::MASK_LIGHT];
		next_st.ana.osc_run = next_st.fc[sensor_pkg::FC_OSC_ON];
		next_st.ana.gain_select = next_st.config_third[1:0];
		next_st.ana.ch3_source_select =
			next_st.config_third[sensor_pkg::CF2_CH3_SEL];
		next_st.ana.integrate = next_st.seq == sensor_pkg::SEQ_INTEG;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.config_second <= sensor_pkg::RST_CFG_FIRST;
			st.seq <= sensor_pkg::SEQ_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Open-drain, active low: pull low while the interrupt is asserted
	assign analog = st.ana;
	assign irq_pin_out = 1'b0;
	assign irq_pin_oe = st.int_drive;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_integ_last;
		st.seq == sensor_pkg::SEQ_INTEG && meas_on && tick && st.cnt == 8'h00;
	endsequence

	sequence s_both_on;
		wr && sys_req.addr == sensor_pkg::A_FUNC_CTRL &&
			sys_req.wdata[1:0] == 2'b11 && st.fc[1:0] == 2'b00 &&
			st.seq == sensor_pkg::SEQ_IDLE;
	endsequence

	a_osc_stopped: assert property (
		!st.fc[sensor_pkg::FC_OSC_ON] |=> st.presc == '0)
		else $error("prescaler runs with oscillator off");
	a_autozero_first: assert property (
		s_both_on |=> ##1 st.seq == sensor_pkg::SEQ_AZERO)
		else $error("auto-zero did not start");
	a_meas_power: assert property (
		!st.fc[sensor_pkg::FC_OSC_ON] |=> st.seq == sensor_pkg::SEQ_IDLE)
		else $error("sequencer runs without power");
	a_pause_off: assert property (
		st.seq == sensor_pkg::SEQ_PAUSE && !st.fc[sensor_pkg::FC_PAUSE_EN]
		|=> st.seq != sensor_pkg::SEQ_PAUSE)
		else $error("wait continues with timer off");
	a_integ_done: assert property (
		s_integ_last |=> analog.integ_done && !$past(analog.integ_done))
		else $error("integration end not signalled");
	a_next_cycle: assert property (
		s_integ_last ##0 !st.fc[sensor_pkg::FC_PAUSE_EN] |=>
		st.seq == sensor_pkg::SEQ_INTEG && st.cnt == $past(st.it_steps))
		else $error("no immediate restart without wait");
	a_max_count: assert property (
		(st.it_steps >= 8'h3f) ? (max_cnt == 16'hffff) :
		(max_cnt == ({8'h00, st.it_steps} + 16'h0001) * 16'h0400 - 16'h0001))
		else $error("maximum count wrong");
	a_long_step: assert property (
		st.sub != 4'h0 |-> st.config_second[sensor_pkg::CF1_LONG_PAUSE] &&
		st.sub <= 4'hb && st.seq == sensor_pkg::SEQ_PAUSE)
		else $error("long wait sub-step out of place");
	a_irq_persistence_reset: assert property (
		!meas_on |=> st.irq_persistence_cnt == 6'h00)
		else $error("persistence count kept while disabled");
	a_low_latch: assert property (
		wr && sys_req.addr == sensor_pkg::A_LOW_LO |=> $stable(st.low_thr))
		else $error("low byte applied before high byte");
	a_set_wins: assert property (
		light_set && wr && sys_req.addr == sensor_pkg::A_FLAGS
		|=> st.status[sensor_pkg::ST_LIGHT])
		else $error("light flag lost to clear");
	a_irq_gate: assert property (
		irq_pin_oe == (st.status[sensor_pkg::ST_LIGHT] &&
		st.irq_mask[sensor_pkg::MASK_LIGHT]))
		else $error("interrupt pin disagrees with flag and mask");
endmodule : light_sensor_control_regs

/* File: hdl/sensor_pkg.sv */
// Constants and types shared by the light sensor control block.
// Assumes a byte register port on the link clock and an ADC front end.
// What this block does
// - Power bit runs the step oscillator.
// - Measurement needs power; both set starts auto-zero.
// - Pause-enable bit switches the wait timer.
// - Integration down counter, steps of 2.78ms.
// - Maximum count 1024 per step, saturates 65535.
// - Wait down counter, loaded value plus one.
// - Long-pause bit stretches wait steps twelvefold.
// - Below lower limit sets light flag.
// - Above upper limit sets light flag.
// - Low byte latched until high byte write.
// - Interrupt pin active when flag and enable.
// - Persistence field sets consecutive out-of-range count.
// - Only channel 0 feeds the comparison.
// - Config bit picks channel 3 photodiode.
// - Two-bit gain field selects 1x to 64x.
// - Saturation flag, cleared by writing one.
// - Light flag, cleared by writing one.
// - Calibration flag, cleared by writing one.
// - Channel 3 data follows source select.
// - Mask bit 4 passes light interrupt.
package sensor_pkg;
	// Register offsets
	localparam logic [7:0] A_FUNC_CTRL = 8'h80;
	localparam logic [7:0] A_INT_STEPS = 8'h81;
	localparam logic [7:0] A_PAUSE_STEPS = 8'h83;
	localparam logic [7:0] A_LOW_LO = 8'h84;
	localparam logic [7:0] A_LOW_HI = 8'h85;
	localparam logic [7:0] A_HIGH_LO = 8'h86;
	localparam logic [7:0] A_HIGH_HI = 8'h87;
	localparam logic [7:0] A_IRQ_PERSISTENCE = 8'h8c;
	localparam logic [7:0] A_CFG_FIRST = 8'h8d;
	localparam logic [7:0] A_CFG_SECOND = 8'h90;
	localparam logic [7:0] A_REV = 8'h91;
	localparam logic [7:0] A_PART = 8'h92;
	localparam logic [7:0] A_FLAGS = 8'h93;
	localparam logic [7:0] A_Z_LO = 8'h94;
	localparam logic [7:0] A_Z_HI = 8'h95;
	localparam logic [7:0] A_Y_LO = 8'h96;
	localparam logic [7:0] A_Y_HI = 8'h97;
	localparam logic [7:0] A_IR1_LO = 8'h98;
	localparam logic [7:0] A_IR1_HI = 8'h99;
	localparam logic [7:0] A_CH3_LO = 8'h9a;
	localparam logic [7:0] A_CH3_HI = 8'h9b;
	localparam logic [7:0] A_CFG_THIRD = 8'h9f;
	localparam logic [7:0] A_CFG_FOURTH = 8'hab;
	localparam logic [7:0] A_AZ_CFG = 8'hd6;
	localparam logic [7:0] A_IRQ_MASK = 8'hdd;
	// Field positions
	localparam int FC_OSC_ON = 0;
	localparam int FC_MEAS_EN = 1;
	localparam int FC_PAUSE_EN = 3;
	localparam int CF1_LONG_PAUSE = 2;
	localparam int CF2_CH3_SEL = 3;
	localparam int ST_SAT = 7;
	localparam int ST_LIGHT = 4;
	localparam int ST_CAL = 3;
	localparam int MASK_LIGHT = 4;
	localparam logic [7:0] FLAG_W1C = 8'h98;
	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_CFG_FIRST = 8'h80;
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int STEP_TIME_NS = 2780000;
	localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
	localparam logic [3:0] LONG_FACTOR = 4'hc;
	// Count limits
	localparam logic [7:0] FULL_STEPS = 8'h3f;
	localparam logic [15:0] MAX_FULL = 16'hffff;
	localparam logic [3:0] IRQ_PERSISTENCE_LINEAR_MAX = 4'h3;
	localparam logic [6:0] IRQ_PERSISTENCE_MULT = 7'h05;
	localparam logic [6:0] IRQ_PERSISTENCE_OFFSET = 7'h0f;

	// Gray codes along idle, auto-zero, integrate, pause
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_AZERO = 2'b01,
		SEQ_INTEG = 2'b11,
		SEQ_PAUSE = 2'b10
	} seq_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic write;
	} reg_req_s;

	typedef struct packed {
		logic [15:0] ch0;
		logic [15:0] ch1;
		logic [15:0] ch2;
		logic [15:0] ch3_x;
		logic [15:0] ch3_ir;
		logic saturated;
	} adc_result_s;

	typedef struct packed {
		logic osc_run;
		logic [1:0] gain_select;
		logic ch3_source_select;
		logic integrate;
		logic autozero_start;
		logic integ_done;
	} analog_ctrl_s;
endpackage : sensor_pkg

/* File: hdl/reg_port_cdc.sv */
// Carries one register access at a time from the link clock to clk_sys.
// Assumes the link side waits for link_busy low before a new access.
module reg_port_cdc (
	input wire logic link_clk,
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic link_access,
	input wire sensor_pkg::reg_req_s link_req,
	output logic link_busy,
	output logic [7:0] link_rdata,
	output logic sys_pulse,
	output sensor_pkg::reg_req_s sys_req,
	input wire logic [7:0] sys_rdata
);
	typedef struct packed {
		sensor_pkg::reg_req_s req;
		logic req_tgl;
		logic ack_s1;
		logic ack_s2;
		logic ack_seen;
		logic busy;
		logic [7:0] rdata;
	} link_state_s;

	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_seen;
		logic ack_tgl;
		logic [7:0] rdata;
	} sys_state_s;

	link_state_s ls, next_ls;
	sys_state_s ss, next_ss;

	// Link side: the request word stays frozen while busy, so the
	// system side may read it once the toggle has been synchronised
	always_comb begin
		next_ls = ls;
		next_ls.ack_s1 = ss.ack_tgl;
		next_ls.ack_s2 = ls.ack_s1;
		if (ls.busy && (ls.ack_s2 != ls.ack_seen)) begin
			next_ls.ack_seen = ls.ack_s2;
			next_ls.busy = 1'b0;
			next_ls.rdata = ss.rdata;
		end else if (!ls.busy && link_access) begin
			next_ls.req = link_req;
			next_ls.req_tgl = !ls.req_tgl;
			next_ls.busy = 1'b1;
		end
	end

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			ls <= '0;
		end else begin
			ls <= next_ls;
		end
	end

	// System side: one pulse per toggle, read data held until next one
	assign sys_pulse = ss.req_s2 != ss.req_seen;
	assign sys_req = ls.req;

	always_comb begin
		next_ss = ss;
		next_ss.req_s1 = ls.req_tgl;
		next_ss.req_s2 = ss.req_s1;
		if (sys_pulse) begin
			next_ss.req_seen = ss.req_s2;
			next_ss.ack_tgl = !ss.ack_tgl;
			next_ss.rdata = sys_rdata;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ss <= '0;
		end else begin
			ss <= next_ss;
		end
	end

	assign link_busy = ls.busy;
	assign link_rdata = ls.rdata;
endmodule : reg_port_cdc

/* File: dv/link_host.sv */
// Host model for the register link: makes the link clock and runs one
// access at a time. Assumes the device answers by dropping link_busy.
module link_host (
	output logic link_clk,
	output logic link_access,
	output sensor_pkg::reg_req_s link_req,
	input wire logic link_busy,
	input wire logic [7:0] link_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic run;
	// Clock stands low between accesses, so idle link logic is not clocked
	initial begin
		run = 1'b1;
		link_clk = 1'b0;
		link_access = 1'b0;
		link_req = '0;
		#13;
		forever #40 link_clk = run ? ~link_clk : 1'b0;
	end
	// One whole access; request held until link_busy is seen low
	task automatic xfer(input logic [7:0] addr, input logic [7:0] wdata,
		input logic write, output logic [7:0] rdata, output logic ok);
		int n;
		run = 1'b1;
		@(negedge link_clk);
		link_req = '{addr: addr, wdata: wdata, write: write};
		link_access = 1'b1;
		@(posedge link_clk);
		ok = 1'b0;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge link_clk);
			#1;
			ok = (link_busy === 1'b0);
		end
		rdata = link_rdata;
		@(negedge link_clk);
		link_access = 1'b0;
		link_req = ~link_req; // Released lines keep no stale value
		run = 1'b0;
	endtask : xfer
endmodule : link_host

/* File: dv/light_sensor_control_regs_tb.sv */
// Self-checking bench for the light sensor control block.
// Assumes the link host model drives the register link.
module light_sensor_control_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int STEPS = 8; // Short step keeps the run brief
	localparam logic [7:0] PART = 8'h3c; // Arbitrary value
	localparam logic [7:0] REV = 8'h5a; // Arbitrary value
	logic clk_sys, rst, link_clk, link_access, link_busy;
	logic adc_valid, calib_done, irq_pin_out, irq_pin_oe;
	logic [7:0] link_rdata;
	sensor_pkg::reg_req_s link_req;
	sensor_pkg::adc_result_s adc_res;
	sensor_pkg::analog_ctrl_s analog;
	int err_count = 0;
	int cmp_count = 0;
	int n;
	light_sensor_control_regs #(.STEP_CYCLES(STEPS), .REV_CODE(REV),
		.PART_CODE(PART)) light_sensor_control_regs_i (.clk_sys(clk_sys),
		.rst(rst), .link_clk(link_clk), .link_access(link_access),
		.link_req(link_req), .link_busy(link_busy),
		.link_rdata(link_rdata), .adc_valid(adc_valid), .adc_res(adc_res),
		.calib_done(calib_done), .analog(analog),
		.irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
	link_host link_host_i (.link_clk(link_clk), .link_access(link_access),
		.link_req(link_req), .link_busy(link_busy),
		.link_rdata(link_rdata));
	always #50 clk_sys = ~clk_sys;
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input string name, input logic [15:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		logic [7:0] r;
		logic ok;
		link_host_i.xfer(a, d, 1'b1, r, ok);
		chk("write answer", ok, 1'b1);
	endtask : wr
	task automatic rd(input logic [7:0] a, exp);
		logic [7:0] r;
		logic ok;
		link_host_i.xfer(a, 8'h00, 1'b0, r, ok);
		chk($sformatf("read %h", a), r, exp);
	endtask : rd
	// One result from the converter; ch3 sources differ to expose the mux
	task automatic adc(input logic [15:0] ch0, input logic sat);
		@(negedge clk_sys);
		adc_res = '{ch0: ch0, ch1: 16'h0123, ch2: 16'h0045,
			ch3_x: 16'h0067, ch3_ir: 16'h0800, saturated: sat};
		adc_valid = 1'b1;
		@(negedge clk_sys);
		adc_valid = 1'b0;
	endtask : adc
	task automatic t_reset();
		chk("irq after reset", irq_pin_oe, 1'b0);
		chk("irq pin data", irq_pin_out, 1'b0);
		rd(sensor_pkg::A_REV, REV);
		rd(sensor_pkg::A_FUNC_CTRL, 8'h00);
		rd(sensor_pkg::A_CFG_FIRST, 8'h80);
		rd(sensor_pkg::A_PART, PART);
		rd(8'h82, 8'h00); // Unmapped reads as zero
		rd(sensor_pkg::A_FLAGS, 8'h00);
	endtask : t_reset
	// Low byte of one pair lands in the other pair with its high byte
	task automatic t_latch();
		wr(sensor_pkg::A_LOW_LO, 8'h34);
		wr(sensor_pkg::A_HIGH_HI, 8'h12);
		rd(sensor_pkg::A_HIGH_LO, 8'h34);
		rd(sensor_pkg::A_HIGH_HI, 8'h12);
		rd(sensor_pkg::A_LOW_LO, 8'h00);
		wr(sensor_pkg::A_LOW_LO, 8'h00);
		wr(sensor_pkg::A_LOW_HI, 8'h01);
	endtask : t_latch
	// Fields first, then both enables in one write
	task automatic t_start();
		wr(sensor_pkg::A_CFG_FIRST, 8'h80);
		wr(sensor_pkg::A_IRQ_PERSISTENCE, 8'h02);
		wr(sensor_pkg::A_IRQ_MASK, 8'h10);
		wr(sensor_pkg::A_CFG_SECOND, 8'h0b);
		fork
			wr(sensor_pkg::A_FUNC_CTRL, 8'h03);
			for (n = 0; n < 100 && analog.autozero_start !== 1'b1; n++) begin
				@(posedge clk_sys);
				#1;
			end
		join
		chk("auto-zero start", n < 100, 1'b1);
		chk("oscillator", analog.osc_run, 1'b1);
		chk("gain", analog.gain_select, 2'h3);
		chk("ch3 source", analog.ch3_source_select, 1'b1);
		@(negedge clk_sys);
		calib_done = 1'b1;
		@(negedge clk_sys);
		calib_done = 1'b0;
		for (n = 0; n < 10 && analog.integrate !== 1'b1; n++) @(negedge clk_sys);
		for (n = 0; n < 50 && analog.integ_done !== 1'b1; n++) @(negedge clk_sys);
		chk("integration span", n >= STEPS && n <= STEPS + 2, 1'b1);
		rd(sensor_pkg::A_FLAGS, 8'h08);
	endtask : t_start
	// Needs two lows in a row; an in-range result restarts the count
	task automatic t_irq_persistence();
		adc(16'h0050, 1'b0);
		adc(16'h0200, 1'b0);
		adc(16'h0050, 1'b0);
		chk("irq early", irq_pin_oe, 1'b0);
		adc(16'h0050, 1'b0);
		chk("irq low limit", irq_pin_oe, 1'b1);
		rd(sensor_pkg::A_FLAGS, 8'h18);
		rd(sensor_pkg::A_CH3_LO, 8'hff);
		rd(sensor_pkg::A_CH3_HI, 8'h03);
		rd(sensor_pkg::A_Z_LO, 8'h50);
		wr(sensor_pkg::A_FLAGS, 8'h10);
		chk("irq cleared", irq_pin_oe, 1'b0);
		adc(16'h0200, 1'b1);
		rd(sensor_pkg::A_FLAGS, 8'h88);
		wr(sensor_pkg::A_FLAGS, 8'h88);
		rd(sensor_pkg::A_FLAGS, 8'h00);
		wr(sensor_pkg::A_HIGH_LO, 8'h00);
		wr(sensor_pkg::A_HIGH_HI, 8'h03);
		adc(16'h0380, 1'b0);
		adc(16'h0380, 1'b0);
		rd(sensor_pkg::A_FLAGS, 8'h10);
		wr(sensor_pkg::A_FUNC_CTRL, 8'h00);
		chk("oscillator off", analog.osc_run, 1'b0);
		chk("integrate off", analog.integrate, 1'b0);
	endtask : t_irq_persistence
	// Two long wait steps, then a wait cut short by clearing its enable
	task automatic t_pause();
		wr(sensor_pkg::A_PAUSE_STEPS, 8'h01);
		wr(sensor_pkg::A_CFG_FIRST, 8'h84);
		fork
			wr(sensor_pkg::A_FUNC_CTRL, 8'h0b);
			for (n = 0; n < 100 && analog.autozero_start !== 1'b1; n++) begin
				@(posedge clk_sys);
				#1;
			end
		join
		@(negedge clk_sys);
		calib_done = 1'b1;
		@(negedge clk_sys);
		calib_done = 1'b0;
		for (n = 0; n < 50 && analog.integ_done !== 1'b1; n++)
			@(negedge clk_sys);
		for (n = 0; n < 400 && analog.integrate !== 1'b1; n++)
			@(negedge clk_sys);
		chk("long wait span", 16'(n), 16'(2 * 12 * STEPS));
		for (n = 0; n < 50 && analog.integ_done !== 1'b1; n++)
			@(negedge clk_sys);
		wr(sensor_pkg::A_FUNC_CTRL, 8'h03);
		chk("wait cut short", analog.integrate, 1'b1);
	endtask : t_pause
	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		adc_valid = 1'b0;
		calib_done = 1'b0;
		adc_res = '0;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		t_reset();
		t_latch();
		t_start();
		t_irq_persistence();
		t_pause();
		end_of_test();
	end
	// Whole run needs well under a millisecond
	initial begin
		#1000000;
		err_count++;
		end_of_test();
	end
endmodule : light_sensor_control_regs_tb
